// ### common/tmdut_pkg.sv
// constants, types and register map of the three-mode down/up timer group
package tmdut_pkg;

  // ==========================================================
  // widths
  localparam int NUM_TIMERS = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int MODE_W = 8;
  localparam int PRE_W = 5;
  localparam int EDGE_CNT_W = 2;

  // ==========================================================
  // register map (word index on the plain register port)
  localparam logic [ADDR_W-1:0] ADDR_RUN = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MODE_BASE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STRIDE = 4'h2;

  // status register bit positions
  localparam int STS_OVF_BIT = 0;
  localparam int STS_VALID_BIT = 1;

  // ==========================================================
  // reset and limit values
  localparam logic [DATA_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [NUM_TIMERS-1:0] RUN_RESET = 3'h0;
  localparam logic [PRE_W-1:0] PRE_ONE = 5'h01;
  localparam logic [PRE_W-1:0] PRE_F8_MASK = 5'h07;
  localparam logic [PRE_W-1:0] PRE_F32_MASK = 5'h1F;
  localparam logic [EDGE_CNT_W-1:0] EDGES_NONE = 2'h0;
  localparam logic [EDGE_CNT_W-1:0] EDGES_ONE = 2'h1;
  localparam logic [EDGE_CNT_W-1:0] EDGES_VALID = 2'h2;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_PULSE = 2'b10,
    MODE_RSVD = 2'b11
  } tmdut_mode_e;

  typedef enum logic [1:0] {
    CLK_F1 = 2'b00,
    CLK_F8 = 2'b01,
    CLK_F32 = 2'b10,
    CLK_RSVD = 2'b11
  } tmdut_clk_e;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_RSVD = 2'b11
  } tmdut_edge_e;

  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    tmdut_clk_e clk_sel;
    logic rsvd;
    logic evt_src;
    tmdut_edge_e edge_sel;
    tmdut_mode_e mode;
  } tmdut_mode_s;

  localparam tmdut_mode_s MODE_RESET = 8'h00;

endpackage

// ### src/tmdut_top.sv
// three 16-bit timers with timer and event counter modes; timer 0 also has pulse measurement mode
module tmdut_top
  import tmdut_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  input wire logic timer0_pulse_input,
  input wire logic [NUM_TIMERS-2:0] timer_event_input,
  input wire logic [NUM_TIMERS-1:0] irq_ack,
  output logic [NUM_TIMERS-1:0] irq
);

  // ==========================================================
  // helpers
  function automatic logic [ADDR_W-1:0] mode_addr(input int i);
    return ADDR_W'(int'(ADDR_MODE_BASE) + i * int'(ADDR_STRIDE));
  endfunction

  function automatic logic [ADDR_W-1:0] cnt_addr(input int i);
    return ADDR_W'(int'(ADDR_CNT_BASE) + i * int'(ADDR_STRIDE));
  endfunction

  function automatic logic edge_hit(input tmdut_edge_e sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      EDGE_RSVD: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ==========================================================
  // state
  logic [NUM_TIMERS-1:0] run_r;
  tmdut_mode_s mode_r [NUM_TIMERS];
  logic [DW-1:0] cnt_r [NUM_TIMERS];
  logic [DW-1:0] reload_r [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] irq_r;
  logic [NUM_TIMERS-1:0] sync1_r;
  logic [NUM_TIMERS-1:0] sync2_r;
  logic [NUM_TIMERS-1:0] prev_r;
  logic [PRE_W-1:0] pre_r;
  logic ovf_flag_r;
  logic [EDGE_CNT_W-1:0] edges_r;
  logic [DW-1:0] rd_data_r;
  logic [DW-1:0] rd_nxt;

  logic [NUM_TIMERS-1:0] pin_rise;
  logic [NUM_TIMERS-1:0] pin_fall;
  logic [NUM_TIMERS-1:0] int_tick_w;
  logic [NUM_TIMERS-1:0] src_tick_w;
  logic [NUM_TIMERS-1:0] cnt_wr_w;
  logic tick_f8;
  logic tick_f32;
  logic pulse_mode;
  logic meas_edge;
  logic ovf_evt;
  logic ovf_sw_clr;
  logic ovf_mode_clr;

  assign rd_data = rd_data_r;
  assign irq = irq_r;

  // ==========================================================
  // input pin synchronisers and edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else if (clk_en) begin
      sync1_r <= {timer_event_input, timer0_pulse_input};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign pin_rise = sync2_r & ~prev_r;
  assign pin_fall = ~sync2_r & prev_r;

  // ==========================================================
  // shared prescaler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (clk_en) begin
      pre_r <= pre_r + PRE_ONE;
    end
  end

  assign tick_f8 = (pre_r & PRE_F8_MASK) == PRE_F8_MASK;
  assign tick_f32 = (pre_r & PRE_F32_MASK) == PRE_F32_MASK;

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= RUN_RESET;
    end else if (clk_en && wr_en && addr == ADDR_RUN) begin
      run_r <= wr_data[NUM_TIMERS-1:0];
    end
  end

  // ==========================================================
  // per-timer counting, down except timer 0 counting up in pulse mode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      logic evt_hit;
      logic down_mode;

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode_r[gi] <= MODE_RESET;
        end else if (clk_en && wr_en && addr == mode_addr(gi)) begin
          mode_r[gi] <= tmdut_mode_s'(wr_data[MODE_W-1:0]);
        end
      end

      always_comb begin
        int_tick_w[gi] = 1'b0;
        unique case (mode_r[gi].clk_sel)
          CLK_F1: int_tick_w[gi] = 1'b1;
          CLK_F8: int_tick_w[gi] = tick_f8;
          CLK_F32: int_tick_w[gi] = tick_f32;
          CLK_RSVD: int_tick_w[gi] = 1'b0;
        endcase
      end

      // other-timer source chains to the previous timer's interrupt pulse
      assign evt_hit = mode_r[gi].evt_src ? irq_r[(gi + NUM_TIMERS - 1) % NUM_TIMERS] :
                       edge_hit(mode_r[gi].edge_sel, pin_rise[gi], pin_fall[gi]);
      assign src_tick_w[gi] = (mode_r[gi].mode == MODE_EVENT) ? evt_hit : int_tick_w[gi];
      assign down_mode = !((gi == 0) && pulse_mode);
      assign cnt_wr_w[gi] = wr_en && addr == cnt_addr(gi);

      if (gi == 0) begin : g_pulse
        always_ff @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            cnt_r[gi] <= CNT_ZERO;
          end else if (clk_en) begin
            if (!down_mode) begin
              if (run_r[gi] && meas_edge) begin
                cnt_r[gi] <= CNT_ZERO;
              end else if (run_r[gi] && int_tick_w[gi]) begin
                cnt_r[gi] <= cnt_r[gi] + CNT_ONE;
              end
            end else if (cnt_wr_w[gi] && !run_r[gi]) begin
              cnt_r[gi] <= wr_data;
            end else if (run_r[gi] && src_tick_w[gi]) begin
              cnt_r[gi] <= (cnt_r[gi] == CNT_ZERO) ? reload_r[gi] : cnt_r[gi] - CNT_ONE;
            end
          end
        end
      end else begin : g_down
        always_ff @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            cnt_r[gi] <= CNT_ZERO;
          end else if (clk_en) begin
            if (cnt_wr_w[gi] && !run_r[gi]) begin
              cnt_r[gi] <= wr_data;
            end else if (run_r[gi] && src_tick_w[gi]) begin
              cnt_r[gi] <= (cnt_r[gi] == CNT_ZERO) ? reload_r[gi] : cnt_r[gi] - CNT_ONE;
            end
          end
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          reload_r[gi] <= CNT_ZERO;
        end else if (clk_en) begin
          if (!down_mode) begin
            if (run_r[gi] && meas_edge) begin
              reload_r[gi] <= cnt_r[gi];
            end
          end else if (cnt_wr_w[gi]) begin
            reload_r[gi] <= wr_data;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_r[gi] <= 1'b0;
        end else if (clk_en) begin
          if (!down_mode) begin
            irq_r[gi] <= run_r[gi] && ((meas_edge && edges_r != EDGES_NONE) || ovf_evt);
          end else begin
            irq_r[gi] <= run_r[gi] && src_tick_w[gi] && cnt_r[gi] == CNT_ZERO;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // timer 0 pulse measurement
  assign pulse_mode = mode_r[0].mode == MODE_PULSE;
  // width: both edges; period: one polarity taken from the edge field
  assign meas_edge = pulse_mode && (mode_r[0].edge_sel == EDGE_BOTH ?
                     (pin_rise[0] | pin_fall[0]) :
                     edge_hit(mode_r[0].edge_sel, pin_rise[0], pin_fall[0]));
  assign ovf_evt = pulse_mode && run_r[0] && int_tick_w[0] && !meas_edge &&
                   cnt_r[0] == CNT_MAX;
  assign ovf_sw_clr = wr_en && addr == ADDR_STATUS && wr_data[STS_OVF_BIT];
  assign ovf_mode_clr = wr_en && addr == mode_addr(0) && run_r[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_r <= EDGES_NONE;
    end else if (clk_en) begin
      if (!run_r[0] || !pulse_mode) begin
        edges_r <= EDGES_NONE;
      end else if (meas_edge && edges_r != EDGES_VALID) begin
        edges_r <= edges_r + EDGES_ONE;
      end
    end
  end

  // set beats any clear arriving in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (ovf_evt) begin
        ovf_flag_r <= 1'b1;
      end else if (ovf_mode_clr || ovf_sw_clr || irq_ack[0]) begin
        ovf_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register read port
  always_comb begin
    rd_nxt = '0;
    if (addr == ADDR_RUN) begin
      rd_nxt = DW'(run_r);
    end
    if (addr == ADDR_STATUS) begin
      rd_nxt[STS_OVF_BIT] = ovf_flag_r;
      rd_nxt[STS_VALID_BIT] = edges_r == EDGES_VALID;
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (addr == mode_addr(i)) begin
        rd_nxt = DW'(mode_r[i]);
      end
      if (addr == cnt_addr(i)) begin
        rd_nxt = (i == 0 && pulse_mode) ? reload_r[i] : cnt_r[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= '0;
    end else if (clk_en) begin
      rd_data_r <= rd_en ? rd_nxt : '0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_stop_hold;
    clk_en && !run_r[1] && !cnt_wr_w[1] |=> $stable(cnt_r[1]);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped timer 1 moved");

  property p_underflow;
    clk_en && run_r[1] && src_tick_w[1] && cnt_r[1] == CNT_ZERO
      |=> cnt_r[1] == $past(reload_r[1]) && irq_r[1];
  endproperty
  a_underflow: assert property (p_underflow) else $error("no reload on underflow");

  property p_count_down;
    clk_en && run_r[2] && src_tick_w[2] && cnt_r[2] != CNT_ZERO
      |=> cnt_r[2] == $past(cnt_r[2]) - CNT_ONE && !irq_r[2];
  endproperty
  a_count_down: assert property (p_count_down) else $error("timer 2 did not decrement");

  property p_wr_stopped;
    clk_en && cnt_wr_w[2] && !run_r[2]
      |=> cnt_r[2] == $past(wr_data) && reload_r[2] == $past(wr_data);
  endproperty
  a_wr_stopped: assert property (p_wr_stopped) else $error("stopped write lost");

  property p_wr_running;
    clk_en && cnt_wr_w[2] && run_r[2] && !src_tick_w[2]
      |=> reload_r[2] == $past(wr_data) && cnt_r[2] == $past(cnt_r[2]);
  endproperty
  a_wr_running: assert property (p_wr_running) else $error("running write hit counter");

  property p_f8_tick;
    clk_en && mode_r[2].mode == MODE_TIMER && mode_r[2].clk_sel == CLK_F8 && int_tick_w[2]
      |=> !int_tick_w[2] [*7];
  endproperty
  a_f8_tick: assert property (p_f8_tick) else $error("divide by eight wrong");

  property p_capture;
    clk_en && pulse_mode && run_r[0] && meas_edge
      |=> cnt_r[0] == CNT_ZERO && reload_r[0] == $past(cnt_r[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_first_edge;
    clk_en && pulse_mode && run_r[0] && meas_edge && edges_r == EDGES_NONE |=> !irq_r[0];
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("irq on first edge");

  property p_overflow;
    clk_en && ovf_evt |=> irq_r[0] && ovf_flag_r;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_ovf_clear;
    clk_en && ovf_mode_clr && !ovf_evt |=> !ovf_flag_r;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("mode write kept overflow");

  property p_pulse_read;
    clk_en && rd_en && addr == cnt_addr(0) && pulse_mode |=> rd_data_r == $past(reload_r[0]);
  endproperty
  a_pulse_read: assert property (p_pulse_read) else $error("pulse read not capture");

  property p_no_write;
    clk_en && pulse_mode && cnt_wr_w[0] && !meas_edge
      |=> $stable(reload_r[0]) &&
          (cnt_r[0] == $past(cnt_r[0]) || cnt_r[0] == $past(cnt_r[0]) + CNT_ONE);
  endproperty
  a_no_write: assert property (p_no_write) else $error("pulse mode count written");

  c_underflow: cover property (clk_en && run_r[1] && src_tick_w[1] && cnt_r[1] == CNT_ZERO);
  c_event: cover property (clk_en && mode_r[2].mode == MODE_EVENT && src_tick_w[2]);
  c_valid: cover property (clk_en && pulse_mode && meas_edge && edges_r == EDGES_VALID);
  c_overflow: cover property (clk_en && ovf_evt);

endmodule

// ### testbench/tmdut_pulse_src.sv
// external pulse source model driving a timer input pin
module tmdut_pulse_src (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [15:0] hi_len,
  input wire logic [15:0] lo_len,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // square wave: rises one cycle after enable, rests low when disabled
  logic [15:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (!en) begin
      pin <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (cnt_r == 16'h0000) begin
      pin <= ~pin;
      cnt_r <= pin ? lo_len - 16'h0001 : hi_len - 16'h0001;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
endmodule

// ### testbench/tb_three_mode_down_up_timer.sv
// self-checking bench for the three-mode down/up timer group
module tb_three_mode_down_up_timer
  import tmdut_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic pin0;
  logic evt;
  logic en_p;
  logic en_e;
  logic [15:0] hi_p;
  logic [15:0] lo_p;
  logic [NUM_TIMERS-1:0] irq_ack;
  logic [NUM_TIMERS-1:0] irq;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  tmdut_top i_tmdut_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .timer0_pulse_input(pin0), .timer_event_input({1'b0, evt}), .irq_ack(irq_ack), .irq(irq));

  tmdut_pulse_src i_tmdut_pulse_src (.ref_clk(ref_clk), .rst_n(rst_n), .en(en_p),
    .hi_len(hi_p), .lo_len(lo_p), .pin(pin0));

  tmdut_pulse_src i_tmdut_pulse_src_evt (.ref_clk(ref_clk), .rst_n(rst_n), .en(en_e),
    .hi_len(16'h0004), .lo_len(16'h0004), .pin(evt));

  always #2 ref_clk = ~ref_clk;

  // ==========================================================
  // hang guard and verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 75000) begin
      failures++;
      close_out();
    end
  end

  task close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // register port and irq helpers
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    d = rd_data;
  endtask

  // edges until the next irq pulse of timer i
  task automatic wt(input int i, output int k);
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (irq[i] !== 1'b1 && k < 70000);
  endtask

  task automatic gap(input int i, output int g);
    int k;
    wt(i, k);
    wt(i, g);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_down;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    int g;
    wr(4'h5, 16'h0003);
    rd(4'h5, a);
    `CHK("cnt_stopped_load", 16'h0003, a)
    rd(4'hF, a);
    `CHK("unmapped", 16'h0000, a)
    wr(ADDR_RUN, 16'h0002);
    gap(1, g);
    `CHK("period_n3", 4, g)
    @(posedge ref_clk);
    addr <= 4'h5;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    rd_en <= 1'b0;
    a = rd_data;
    @(posedge ref_clk);
    b = rd_data;
    `CHK("live", (a == 16'h0000) ? 16'h0003 : a - 16'h0001, b)
    wr(4'h5, 16'h0007);
    wt(1, g);
    gap(1, g);
    `CHK("period_after_reload", 8, g)
    wr(ADDR_RUN, 16'h0000);
    rd(4'h5, a);
    repeat (5) @(posedge ref_clk);
    rd(4'h5, b);
    `CHK("stopped", a, b)
    $display("test down done");
  endtask

  task automatic t_clk;
    logic [7:0] cs[3] = '{8'h00, 8'h40, 8'h80};
    int dv[3] = '{2, 16, 64};
    int g;
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_RUN, 16'h0000);
      wr(4'h6, {8'h00, cs[c]});
      wr(4'h7, 16'h0001);
      wr(ADDR_RUN, 16'h0004);
      gap(2, g);
      `CHK("clk_period", dv[c], g)
    end
    $display("test clock source done");
  endtask

  task automatic t_event;
    logic [7:0] em[3] = '{8'h01, 8'h05, 8'h09};
    int eg[3] = '{16, 16, 8};
    int g;
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_RUN, 16'h0000);
      wr(4'h4, {8'h00, em[c]});
      wr(4'h5, 16'h0001);
      wr(ADDR_RUN, 16'h0002);
      en_e <= 1'b1;
      gap(1, g);
      `CHK("event_period", eg[c], g)
    end
    // timer 2 counts timer 1 underflows: two per reload
    wr(ADDR_RUN, 16'h0000);
    wr(4'h6, 16'h0011);
    wr(4'h7, 16'h0001);
    wr(ADDR_RUN, 16'h0006);
    gap(2, g);
    `CHK("chain_period", 16, g)
    en_e <= 1'b0;
    $display("test event done");
  endtask

  task automatic t_pulse;
    logic [7:0] md[3] = '{8'h02, 8'h06, 8'h0A};
    logic [15:0] hi[3] = '{16'h000A, 16'h000A, 16'h000F};
    logic [15:0] lo[3] = '{16'h0014, 16'h0014, 16'h000F};
    logic [15:0] cap[3] = '{16'h001D, 16'h001D, 16'h000E};
    int e2[3] = '{31, 41, 16};
    logic [DATA_W-1:0] d;
    int k;
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_RUN, 16'h0000);
      hi_p <= hi[c];
      lo_p <= lo[c];
      wr(ADDR_MODE_BASE, {8'h00, md[c]});
      rd(ADDR_STATUS, d);
      `CHK("sts_idle", 16'h0000, d)
      wr(ADDR_RUN, 16'h0001);
      en_p <= 1'b1;
      wt(0, k);
      `CHK("first_irq", 1'b1, k >= e2[c] && k <= e2[c] + 8)
      wt(0, k);
      rd(ADDR_CNT_BASE, d);
      `CHK("capture", cap[c], d)
      rd(ADDR_STATUS, d);
      `CHK("sts_valid", 16'h0002, d)
      wr(ADDR_CNT_BASE, 16'h1234);
      rd(ADDR_CNT_BASE, d);
      `CHK("cnt_wr_ignored", cap[c], d)
      en_p <= 1'b0;
    end
    $display("test pulse measure done");
  endtask

  // preload timer 0 in timer mode, then count up in pulse mode until it overflows
  task automatic ovf_run(input logic [DATA_W-1:0] s, input int n);
    int k;
    wr(ADDR_RUN, 16'h0000);
    wr(ADDR_MODE_BASE, 16'h0000);
    wr(ADDR_CNT_BASE, s);
    wr(ADDR_MODE_BASE, 16'h0002);
    wr(ADDR_RUN, 16'h0001);
    wt(0, k);
    `CHK("ovf_time", n, k)
  endtask

  task automatic t_ovf;
    logic [DATA_W-1:0] d;
    ovf_run(16'h0000, 65537);
    rd(ADDR_STATUS, d);
    `CHK("ovf_set", 16'h0001, d)
    @(posedge ref_clk);
    irq_ack <= 3'h1;
    @(posedge ref_clk);
    irq_ack <= 3'h0;
    rd(ADDR_STATUS, d);
    `CHK("ovf_ack", 16'h0000, d)
    ovf_run(16'hFFF0, 17);
    wr(ADDR_RUN, 16'h0000);
    wr(ADDR_MODE_BASE, 16'h0002);
    rd(ADDR_STATUS, d);
    `CHK("ovf_keep_stopped", 16'h0001, d)
    wr(ADDR_RUN, 16'h0001);
    wr(ADDR_MODE_BASE, 16'h0002);
    rd(ADDR_STATUS, d);
    `CHK("ovf_mode_clr", 16'h0000, d)
    ovf_run(16'hFFF0, 17);
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS, d);
    `CHK("ovf_sw_clr", 16'h0000, d)
    $display("test overflow done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    irq_ack = '0;
    en_p = 1'b0;
    en_e = 1'b0;
    hi_p = 16'h000A;
    lo_p = 16'h0014;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_down();
    t_clk();
    t_event();
    t_pulse();
    t_ovf();
    close_out();
  end
endmodule
